// [logic/ppfh_pkg.sv]
// Purpose: constants for the forward parallel port handshake block
// Assumes: 125 MHz system clock
// Notes:   times in ns, cycle counts derived from the clock period
package ppfh_pkg;
    localparam int CLK_PERIOD_NS   = 8;
    // fifo mode (compatible strobe) timing
    localparam int FIFO_SETUP_NS   = 600;
    localparam int FIFO_PULSE_NS   = 600;
    localparam int FIFO_GAP_NS     = 680;
    localparam int FIFO_SETUP_CYC  = (FIFO_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_PULSE_CYC  = (FIFO_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_GAP_CYC    = (FIFO_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ecp forward timing
    localparam int ECP_DELAY_NS    = 80;
    localparam int ECP_DELAY_CYC   = (ECP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // epp wait filter and command delay
    localparam int WAIT_SETTLE_NS  = 50;
    localparam int WAIT_SETTLE_CYC = (WAIT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EPP_CMD_MIN_NS  = 60;
    localparam int EPP_CMD_CYC     = (EPP_CMD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 8;
    // transfer modes
    localparam logic [1:0] MODE_FIFO = 2'h0;
    localparam logic [1:0] MODE_ECP  = 2'h1;
    localparam logic [1:0] MODE_EPP  = 2'h2;
    typedef enum logic [2:0] {
        PPFH_IDLE, PPFH_SETUP, PPFH_STROBE, PPFH_WAIT_ACK, PPFH_RELEASE, PPFH_WAIT_DONE
    } ppfh_state_t;
endpackage

// [logic/ppfh_core.sv]
// Purpose: forward transfers for fifo, ecp and epp 1.9 write modes
// Assumes: pins synchronous to sys_clk_in, synchronous active-high reset
// Notes:   the byte source is a valid/ready stream fed by dma logic upstream
`timescale 1ns/1ps
`default_nettype none
module ppfh_core (
    // clock and reset
    input  wire  logic                  sys_clk_in,
    input  wire  logic                  reset_in,
    // mode select
    input  wire  logic [1:0]            mode_in,
    // byte stream from the dma side
    input  wire  logic [7:0]            byte_data_in,
    input  wire  logic                  byte_valid_in,
    output logic                        byte_ready_out,
    // peripheral pins
    input  wire  logic                  busy_in,
    input  wire  logic                  n_ack_in,
    input  wire  logic                  n_fault_in,
    input  wire  logic                  n_wait_in,
    output logic [7:0]                  port_data_lines_out,
    output logic                        n_strobe_out,
    output logic                        n_write_out,
    // status
    output logic                        reverse_req_out,
    output logic                        done_out
);
    import ppfh_pkg::*;

    ppfh_state_t          state_r;
    logic [CNT_W-1:0]     cnt_r;
    logic                 wait_raw_r;
    logic [CNT_W-1:0]     wait_cnt_r;
    logic                 wait_ok_r;   // settled nwait, active high = asserted low
    logic                 take;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction

    // every mode needs busy low to take a byte; epp also waits for settled nwait released
    assign take = (state_r == PPFH_IDLE) && byte_valid_in && !busy_in
                  && (mode_in != MODE_EPP || !wait_ok_r);

    // nwait ringing filter: settle after a run of stable samples
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            wait_raw_r <= 1'b1;
            wait_cnt_r <= '0;
            wait_ok_r  <= 1'b0;
        end else begin
            wait_raw_r <= n_wait_in;
            if (n_wait_in != wait_raw_r) begin
                wait_cnt_r <= '0;
            end else if (wait_cnt_r < cyc(WAIT_SETTLE_CYC)) begin
                wait_cnt_r <= wait_cnt_r + 1'b1;
            end else begin
                wait_ok_r <= !wait_raw_r;
            end
        end
    end

    // reverse request is only a reported level; no direction change here
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            reverse_req_out <= 1'b0;
        end else begin
            reverse_req_out <= (mode_in == MODE_ECP) && !n_fault_in;
        end
    end

    // main handshake engine; n_ack_in deliberately unused in every mode
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            state_r             <= PPFH_IDLE;
            cnt_r               <= '0;
            port_data_lines_out <= 8'h00;
            n_strobe_out        <= 1'b1;
            n_write_out         <= 1'b1;
            byte_ready_out      <= 1'b0;
            done_out            <= 1'b0;
        end else begin
            byte_ready_out <= 1'b0;
            done_out       <= 1'b0;
            unique case (state_r)
                PPFH_IDLE: begin
                    n_strobe_out <= 1'b1;
                    n_write_out  <= 1'b1;
                    cnt_r        <= '0;
                    if (take) begin
                        port_data_lines_out <= byte_data_in;
                        byte_ready_out      <= 1'b1;
                        if (mode_in == MODE_EPP) begin
                            n_write_out <= 1'b0;
                        end
                        state_r <= PPFH_SETUP;
                    end
                end
                PPFH_SETUP: begin
                    // data held before strobe falls
                    cnt_r <= cnt_r + 1'b1;
                    if (mode_in == MODE_EPP) begin
                        // settled wait asserted, then delay into the window
                        if (!wait_ok_r) begin
                            cnt_r <= '0;
                        end else if (cnt_r >= cyc(EPP_CMD_CYC)) begin
                            n_strobe_out <= 1'b0;
                            cnt_r        <= '0;
                            state_r      <= PPFH_WAIT_ACK;
                        end
                    end else if (cnt_r >= cyc(mode_in == MODE_FIFO ? FIFO_SETUP_CYC
                                                                     : ECP_DELAY_CYC)) begin
                        n_strobe_out <= 1'b0;
                        cnt_r        <= '0;
                        state_r      <= PPFH_STROBE;
                    end
                end
                PPFH_STROBE: begin
                    // fifo mode holds a minimum pulse; ecp waits busy high
                    cnt_r <= cnt_r + 1'b1;
                    if (mode_in == MODE_FIFO ? (cnt_r >= cyc(FIFO_PULSE_CYC))
                                             : busy_in) begin
                        cnt_r   <= '0;
                        state_r <= PPFH_RELEASE;
                    end
                end
                PPFH_WAIT_ACK: begin
                    // epp: command held until settled wait deasserts
                    if (wait_ok_r) begin
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                        if (cnt_r >= cyc(EPP_CMD_CYC)) begin
                            n_strobe_out <= 1'b1;
                            n_write_out  <= 1'b1;
                            done_out     <= 1'b1;
                            state_r      <= PPFH_IDLE;
                        end
                    end
                end
                PPFH_RELEASE: begin
                    // ecp spaces strobe release off busy assertion
                    cnt_r <= cnt_r + 1'b1;
                    if (mode_in == MODE_FIFO || cnt_r >= cyc(ECP_DELAY_CYC)) begin
                        n_strobe_out <= 1'b1;
                        cnt_r        <= '0;
                        state_r      <= PPFH_WAIT_DONE;
                    end
                end
                PPFH_WAIT_DONE: begin
                    // next byte only after busy low; fifo adds the busy-to-strobe gap
                    if (busy_in) begin
                        cnt_r <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                        if (mode_in != MODE_FIFO || cnt_r >= cyc(FIFO_GAP_CYC
                                                                  - FIFO_SETUP_CYC)) begin
                            done_out <= 1'b1;
                            state_r  <= PPFH_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // assertion helpers: how long the data has stood and the strobe has been low;
    // both saturate, so a long epp command cannot wrap into a false short count
    logic [7:0]           data_seen_r;
    logic [CNT_W-1:0]     data_age_r;
    logic [CNT_W-1:0]     low_age_r;

    // data age restarts on any change of the lines
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            data_seen_r <= 8'h00;
            data_age_r  <= '0;
        end else begin
            data_seen_r <= port_data_lines_out;
            if (port_data_lines_out != data_seen_r) begin
                data_age_r <= '0;
            end else if (data_age_r != '1) begin
                data_age_r <= data_age_r + 1'b1;
            end
        end
    end

    // strobe age counts low cycles, cleared while the strobe is high
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            low_age_r <= '0;
        end else if (n_strobe_out) begin
            low_age_r <= '0;
        end else if (low_age_r != '1) begin
            low_age_r <= low_age_r + 1'b1;
        end
    end

    // idle strobe stays high
    AST_IDLE_STROBE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_r == PPFH_IDLE && $past(state_r) == PPFH_IDLE) |-> n_strobe_out)
        else $error("strobe low while idle");
    // transfer begins only from idle
    AST_FROM_IDLE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        $rose(byte_ready_out) |-> $past(state_r) == PPFH_IDLE)
        else $error("transfer not started from idle");
    // strobe falls only after a setup phase
    AST_STROBE_FALL: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        $fell(n_strobe_out) |-> $past(state_r) == PPFH_SETUP)
        else $error("strobe fell outside setup");
    // data stable during the strobe
    AST_DATA_STABLE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (!n_strobe_out && $past(!n_strobe_out)) |-> $stable(port_data_lines_out))
        else $error("data moved during strobe");
    // ecp strobe rises only out of the release state, with busy still high
    AST_ECP_RELEASE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($rose(n_strobe_out) && mode_in == MODE_ECP && state_r == PPFH_WAIT_DONE)
        |-> $past(state_r) == PPFH_RELEASE && $past(busy_in))
        else $error("ecp strobe released early");
    // settled flag needs stable input
    AST_WAIT_FILTER: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        $changed(wait_ok_r) |-> $past(n_wait_in, 2) == $past(n_wait_in))
        else $error("wait settled on a transition");
    // write line high when no epp write
    AST_WRITE_IDLE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (mode_in != MODE_EPP && $past(mode_in) != MODE_EPP && state_r != PPFH_IDLE)
        |-> n_write_out)
        else $error("write active outside epp");
    // epp command asserts only with settled wait
    AST_EPP_CMD: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($fell(n_strobe_out) && mode_in == MODE_EPP) |-> $past(wait_ok_r))
        else $error("command without settled wait");
    // epp command drops only after wait released
    AST_EPP_REL: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($rose(n_strobe_out) && $past(state_r) == PPFH_WAIT_ACK) |-> !$past(wait_ok_r))
        else $error("command dropped under wait");
    // write line is low only inside the epp setup and command states
    AST_WRITE_OUTSIDE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        (state_r != PPFH_SETUP && state_r != PPFH_WAIT_ACK) |-> n_write_out)
        else $error("write low outside a write cycle");
    // a byte is only taken while busy is low
    AST_TAKE_NOT_BUSY: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        $rose(byte_ready_out) |-> !$past(busy_in))
        else $error("byte taken under busy");
    // a finished transfer leaves the port idle with the strobe high
    AST_DONE_IDLE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        done_out |-> (state_r == PPFH_IDLE && n_strobe_out))
        else $error("transfer ended away from idle");
    // reverse request follows fault one cycle later, in ecp mode only
    AST_REVERSE_ECP: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        reverse_req_out == ($past(mode_in) == MODE_ECP && !$past(n_fault_in)))
        else $error("reverse request wrong");
    // every strobe fall has at least the ecp setup behind it
    AST_SETUP_ALL: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        $fell(n_strobe_out) |-> data_age_r >= cyc(ECP_DELAY_CYC))
        else $error("strobe fell on fresh data");
    // fifo strobe falls only after the full setup time
    AST_FIFO_SETUP: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($fell(n_strobe_out) && mode_in == MODE_FIFO) |-> data_age_r >= cyc(FIFO_SETUP_CYC))
        else $error("fifo setup too short");
    // fifo strobe pulse keeps its minimum width
    AST_FIFO_PULSE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($rose(n_strobe_out) && mode_in == MODE_FIFO) |-> low_age_r >= cyc(FIFO_PULSE_CYC))
        else $error("fifo strobe pulse too short");
    // ecp release waits out the busy spacing, with busy high ECP_DELAY_CYC cycles before the release
    AST_ECP_HOLD: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($rose(n_strobe_out) && mode_in == MODE_ECP) |-> $past(busy_in, ECP_DELAY_CYC))
        else $error("ecp release without busy");
    // epp command waits the minimum delay after the settled wait
    AST_EPP_SETTLE: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($fell(n_strobe_out) && mode_in == MODE_EPP) |-> $past(wait_ok_r, EPP_CMD_CYC))
        else $error("epp command too early");
    // epp command release waits the minimum delay after wait drops
    AST_EPP_HOLDOFF: assert property (@(posedge sys_clk_in) disable iff (reset_in)
        ($rose(n_strobe_out) && mode_in == MODE_EPP) |-> !$past(wait_ok_r, EPP_CMD_CYC))
        else $error("epp release too early");

    // main scenarios: one transfer per mode, a reverse request and a ringing wait
    COV_FIFO_XFER: cover property (@(posedge sys_clk_in) done_out && mode_in == MODE_FIFO);
    COV_ECP_XFER:  cover property (@(posedge sys_clk_in) done_out && mode_in == MODE_ECP);
    COV_EPP_XFER:  cover property (@(posedge sys_clk_in) done_out && mode_in == MODE_EPP);
    COV_REVERSE:   cover property (@(posedge sys_clk_in) reverse_req_out);
    COV_WAIT_RING: cover property (@(posedge sys_clk_in)
        mode_in == MODE_EPP && state_r == PPFH_SETUP && n_wait_in != wait_raw_r);
endmodule
`default_nettype wire

// [bench/ppfh_periph_model.sv]
// Purpose: peripheral at the far end of the forward port
// Assumes: answers on host clock edges, one delay for every answer
// Notes:   an optional short wait pulse before the real one probes the filter
`timescale 1ns/1ps
`default_nettype none
module ppfh_periph_model (
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       reset_in,
    // host pins
    input  wire logic [7:0] data_in,
    input  wire logic       n_strobe_in,
    input  wire logic       n_write_in,
    // behaviour control
    input  wire logic [7:0] delay_in,
    input  wire logic       glitch_in,
    // answers
    output logic            busy_out,
    output logic            n_wait_out,
    output logic            got_out,
    output logic [7:0]      got_byte_out
);
    int n;
    // bounded so a stuck host cannot hang the model
    task automatic until_stb(input logic lvl);
        n = 0;
        while (n_strobe_in !== lvl && n < 4000) begin
            @(posedge sys_clk_in);
            n++;
        end
    endtask
    // hand the taken byte to the bench for one cycle
    task automatic take_byte;
        got_byte_out = data_in;
        got_out = 1'b1;
        @(posedge sys_clk_in);
        #1 got_out = 1'b0;
    endtask
    // one handshake per pass; idle leaves busy low and wait released
    initial begin
        busy_out = 1'b0;
        n_wait_out = 1'b1;
        got_out = 1'b0;
        got_byte_out = 8'h00;
        forever begin
            @(posedge sys_clk_in);
            if (!reset_in && n_write_in === 1'b0) begin
                if (glitch_in) begin
                    #1 n_wait_out = 1'b0;
                    repeat (2) @(posedge sys_clk_in);
                    #1 n_wait_out = 1'b1;
                end
                repeat (delay_in) @(posedge sys_clk_in);
                #1 n_wait_out = 1'b0;
                until_stb(1'b0);
                repeat (delay_in) @(posedge sys_clk_in);
                #1 n_wait_out = 1'b1;
                take_byte();
                until_stb(1'b1);
            end else if (!reset_in && n_strobe_in === 1'b0) begin
                repeat (delay_in) @(posedge sys_clk_in);
                #1 busy_out = 1'b1;
                until_stb(1'b1);
                repeat (delay_in) @(posedge sys_clk_in);
                #1 busy_out = 1'b0;
                take_byte();
            end
        end
    end
endmodule
`default_nettype wire

// [bench/parallel_port_forward_handshake_test.sv]
// Purpose: self-checking bench for the forward handshake core
// Assumes: peripheral model answers strobes, wait and busy
// Notes:   expected bytes kept in a queue, pin timing watched every edge
`timescale 1ns/1ps
`default_nettype none
module parallel_port_forward_handshake_test;
    import ppfh_pkg::*;
    logic       sys_clk_in = 1'b0;
    logic       reset_in = 1'b1;
    logic [1:0] mode_in = MODE_FIFO;
    logic [7:0] byte_data_in = 8'h00;
    logic       byte_valid_in = 1'b0;
    logic       n_ack_in = 1'b1;
    logic       n_fault_in = 1'b1;
    logic [7:0] dly = 8'h01;
    logic       glitch = 1'b0;
    logic       byte_ready_out, busy_in, n_wait_in, n_strobe_out, n_write_out;
    logic       reverse_req_out, done_out, got, prev_stb, prev_wait;
    logic [7:0] port_data_lines_out, got_byte, prev_data;
    logic [7:0] expq[$];
    int         fails = 0, check_count = 0, dcnt, lcnt, wcnt, dones = 0, sent = 0;
    localparam logic [1:0] MODES [3] = '{MODE_FIFO, MODE_ECP, MODE_EPP};
    // clock at 125 MHz
    always #4 sys_clk_in = ~sys_clk_in;
    ppfh_core i_ppfh_core (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .mode_in(mode_in),
        .byte_data_in(byte_data_in), .byte_valid_in(byte_valid_in),
        .byte_ready_out(byte_ready_out), .busy_in(busy_in), .n_ack_in(n_ack_in),
        .n_fault_in(n_fault_in), .n_wait_in(n_wait_in), .port_data_lines_out(port_data_lines_out),
        .n_strobe_out(n_strobe_out), .n_write_out(n_write_out),
        .reverse_req_out(reverse_req_out), .done_out(done_out));
    ppfh_periph_model i_ppfh_periph_model (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .data_in(port_data_lines_out), .n_strobe_in(n_strobe_out), .n_write_in(n_write_out),
        .delay_in(dly), .glitch_in(glitch), .busy_out(busy_in), .n_wait_out(n_wait_in),
        .got_out(got), .got_byte_out(got_byte));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // valid stays up across bytes, so back-to-back takes are exercised
    task automatic send(input logic [7:0] b);
        int k;
        byte_data_in = b;
        byte_valid_in = 1'b1;
        expq.push_back(b);
        sent++;
        k = 0;
        do begin
            @(posedge sys_clk_in);
            k++;
        end while (byte_ready_out !== 1'b1 && k < 3000);
        #1;
        if (k >= 3000) fails++;
        if (k >= 3000) tally_and_finish();
    endtask
    task automatic drain;
        int k;
        byte_valid_in = 1'b0;
        for (k = 0; k < 5000 && (expq.size() != 0 || dones != sent); k++) @(posedge sys_clk_in);
        #1;
        if (k >= 5000) fails++;
        if (k >= 5000) tally_and_finish();
    endtask
    // acknowledge line is pure noise to the design
    always @(posedge sys_clk_in) #1 n_ack_in = 1'($urandom);
    // pin monitor: bytes, strobe edges, stability counts
    always @(posedge sys_clk_in) begin
        if (got === 1'b1) chk(got_byte, (expq.size() != 0) ? expq.pop_front() : 9'h100);
        if (done_out === 1'b1) dones++;
        if (!reset_in && mode_in != MODE_EPP) chk(n_write_out, 1'b1);
        if (!reset_in && prev_stb === 1'b1 && n_strobe_out === 1'b0) begin
            if (mode_in == MODE_EPP) begin
                chk({n_write_out, n_wait_in}, 2'h0);
                chk(wcnt >= (WAIT_SETTLE_NS + 60) / CLK_PERIOD_NS, 1);
                chk(wcnt <= (WAIT_SETTLE_NS + 210) / CLK_PERIOD_NS, 1);
            end else begin
                chk(busy_in, 1'b0);
                chk(dcnt >= ((mode_in == MODE_FIFO) ? FIFO_SETUP_CYC : 1), 1);
            end
        end
        if (!reset_in && prev_stb === 1'b0 && n_strobe_out === 1'b1) begin
            if (mode_in == MODE_EPP) begin
                chk(n_wait_in, 1'b1);
                chk(wcnt >= (WAIT_SETTLE_NS + 60) / CLK_PERIOD_NS, 1);
                chk(wcnt <= (WAIT_SETTLE_NS + 190) / CLK_PERIOD_NS, 1);
            end else begin
                chk(busy_in, 1'b1);
                if (mode_in == MODE_FIFO) chk(lcnt >= FIFO_PULSE_CYC, 1);
            end
        end
        dcnt = (port_data_lines_out === prev_data) ? dcnt + 1 : 0;
        lcnt = (n_strobe_out === 1'b1) ? 0 : lcnt + 1;
        wcnt = (n_wait_in === prev_wait) ? wcnt + 1 : 0;
        prev_stb = n_strobe_out;
        prev_data = port_data_lines_out;
        prev_wait = n_wait_in;
    end
    // main sequence
    initial begin
        void'($urandom(32'hf2b5f106));
        repeat (10) @(posedge sys_clk_in);
        #1 chk({n_strobe_out, n_write_out, reverse_req_out, done_out, byte_ready_out}, 5'h18);
        chk(port_data_lines_out, 8'h00);
        reset_in = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        #1;
        for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 2; s++) begin
                mode_in = MODES[m];
                dly = s ? 8'h14 : 8'h01;
                glitch = s[0];
                send(s ? 8'hff : 8'h00);
                repeat (3) send(8'($urandom));
                drain();
                chk({n_strobe_out, busy_in}, 2'h2);
            end
        end
        // reverse request only reported while in ecp mode
        for (int m = 0; m < 2; m++) begin
            mode_in = MODES[m];
            n_fault_in = 1'b0;
            repeat (3) @(posedge sys_clk_in);
            #1 chk(reverse_req_out, MODES[m] == MODE_ECP);
            n_fault_in = 1'b1;
            repeat (3) @(posedge sys_clk_in);
            #1 chk(reverse_req_out, 1'b0);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
